/* logic/spi_master_regs.svh */
// spi master register map, field positions, reset values and rate counts
// included by spi_rate_gen and spi_master_with_dma; holds definitions only
`ifndef SPI_MASTER_REGS_SVH
`define SPI_MASTER_REGS_SVH

`define ADR_XFER_CTRL  8'h0D
`define ADR_SER_WORD   8'h0E
`define ADR_BLK_CTRL   8'h53
`define ADR_BLK_START  8'h54
`define ADR_BLK_LEN    8'h55

`define F_MODE      15
`define F_RATE_HI   14
`define F_RATE_LO   12
`define F_ICS       11
`define F_QSEL      9
`define F_MULTI     8
`define F_DONE      7
`define F_CLR       6
`define F_RCV       5
`define F_SEND      4
`define F_CNT_HI    3

`define F_NEWINT    5
`define F_SETMODE   4
`define F_REWIND    3
`define F_DIR       2
`define F_BEN       1
`define F_BUSY      0

`define START_HI    13
`define LEN_HI      11

`define CNT_RST         4'h1
`define DMA_WORD_BYTES  4'h2
`define INT_CMD         8'h03

`define CLK_KHZ     200000
`define RATE_KHZ_0  32768
`define RATE_KHZ_1  16384
`define RATE_KHZ_2  13107
`define RATE_KHZ_3  10922
`define RATE_KHZ_4  8192
`define RATE_KHZ_5  4096
`define HALF_CYC(k) (((`CLK_KHZ) + 2 * (k) - 1) / (2 * (k)))
`define HALF_0      `HALF_CYC(`RATE_KHZ_0)
`define HALF_1      `HALF_CYC(`RATE_KHZ_1)
`define HALF_2      `HALF_CYC(`RATE_KHZ_2)
`define HALF_3      `HALF_CYC(`RATE_KHZ_3)
`define HALF_4      `HALF_CYC(`RATE_KHZ_4)
`define HALF_5      `HALF_CYC(`RATE_KHZ_5)

`endif

/* logic/spi_master_pkg.sv */
// state and data types used by spi_master_with_dma
// no dependencies
package spi_master_pkg;

	typedef enum logic {SER_IDLE, SER_RUN} ser_state_e;

	typedef enum logic [2:0] {
		DMA_IDLE,
		DMA_READ,
		DMA_LOAD,
		DMA_KICK,
		DMA_WAIT,
		DMA_STORE
	} dma_state_e;

	typedef logic [15:0] word_t;
	typedef logic [7:0]  byte_t;

endpackage

/* logic/spi_line_sync.sv */
// two-flop synchroniser for the four serial data input lines
// inputs come from pins outside the clock domain
`timescale 1ns/1ps
module spi_line_sync
(
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       ce,
	input  wire logic [3:0] din,
	output logic      [3:0] dout
);
	logic [3:0] meta;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta <= 4'h0;
			dout <= 4'h0;
		end
		else if (ce)
		begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule

/* logic/spi_rate_gen.sv */
// serial clock generator: divides clk down to the selected link rate
// sck rests low whenever run is low; rise and fall mark the toggles
`timescale 1ns/1ps
`include "spi_master_regs.svh"
module spi_rate_gen
(
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       ce,
	input  wire logic       run,
	input  wire logic [2:0] rate_select,
	output logic            sck,
	output logic            rise,
	output logic            fall
);
	logic [4:0] cnt;
	logic [4:0] half;
	logic       wrap;

	// counts round up, so the link never runs above the nominal rate
	function automatic logic [4:0] half_count(input logic [2:0] sel);
		case (sel)
			3'h0: half_count = 5'(`HALF_0);
			3'h1: half_count = 5'(`HALF_1);
			3'h2: half_count = 5'(`HALF_2);
			3'h3: half_count = 5'(`HALF_3);
			3'h4: half_count = 5'(`HALF_4);
			default: half_count = 5'(`HALF_5);
		endcase
	endfunction

	assign half = half_count(rate_select);
	assign wrap = run && (cnt >= half - 5'h01);
	assign rise = wrap && !sck;
	assign fall = wrap && sck;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt <= 5'h00;
			sck <= 1'b0;
		end
		else if (ce)
		begin
			if (!run)
			begin
				cnt <= 5'h00;
				sck <= 1'b0;
			end
			else if (wrap)
			begin
				cnt <= 5'h00;
				sck <= !sck;
			end
			else
				cnt <= cnt + 5'h01;
		end
	end
endmodule

/* logic/spi_master_with_dma.sv */
// spi master with four-word buffer and block-move engine to working sram
// assumes one clock; sram returns read data in the cycle after sram_re;
// chip select is a general-purpose pin driven by software
// Functional notes
// RQ1 - software sets master_enable before any operation; triggers need it
// RQ2 - rate_select picks one of six serial clock rates
// RQ3 - four-entry sixteen-bit buffer for transmitted and received words
// RQ4 - single line drives one output and samples one input; quad bidirectional
// RQ5 - multi-line enable selects dual or quad by the select bit
// RQ6 - edge select: 0 samples on rising, 1 on falling clock edge
// RQ7 - each trigger moves exactly the programmed byte count
// RQ8 - send trigger shifts buffered transmit data out
// RQ9 - receive trigger clocks slave data into the buffer
// RQ10 - flag clear resets control flags including transfer done
// RQ11 - transfer done flag in status bit 7 after each transfer
// RQ12 - internal command select makes the master issue its own command byte
// RQ13 - data write loads a transmit word; read returns last received word
// RQ14 - block engine runs only while enabled and shows a busy bit
// RQ15 - direction 1 moves link to sram, 0 moves sram to link
// RQ16 - auto rewind restores the sram index at block completion
// RQ17 - fourteen-bit start address; writing the word count launches
// RQ18 - software keeps block length at or below 4095 words
// RQ19 - with mode setting enabled, control bit 15 picks improved mode
// RQ20 - improved mode allows data access without waiting for done
// RQ21 - new event mode signals only after the last word has left
// RQ22 - software drives chip select itself around each transaction
// RQ23 - serial clock toggles only during a transfer, else rests low
`timescale 1ns/1ps
`include "spi_master_regs.svh"
module spi_master_with_dma
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        ce,
	input  wire logic        master_enable,
	input  wire logic [7:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	output logic             sck,
	input  wire logic [3:0]  sio_in,
	output logic      [3:0]  sio_out,
	output logic      [3:0]  sio_oe,
	output logic      [13:0] sram_addr,
	output logic      [15:0] sram_wdata,
	output logic             sram_we,
	output logic             sram_re,
	input  wire logic [15:0] sram_rdata,
	output logic             dma_event
);
	// transfer control fields
	logic        mode_sel;
	logic [2:0]  rate_select;
	logic        internal_command_select;
	logic        quad_sel;
	logic        multi_en;
	logic [3:0]  byte_total;
	logic        transfer_done_flag;

	// block-move control fields
	logic        new_event_mode;
	logic        set_mode;
	logic        index_auto_rewind;
	logic        dma_dir;
	logic        dma_en;
	logic [13:0] sram_start_pointer;
	logic [11:0] word_count;
	logic [13:0] idx;
	logic [11:0] left;
	spi_master_pkg::word_t     dma_word;
	spi_master_pkg::dma_state_e dstate;
	spi_master_pkg::dma_state_e next_dstate;

	// buffer
	spi_master_pkg::word_t buf_mem [4];
	logic [1:0]  wptr;
	logic [1:0]  rptr;
	logic [1:0]  tx_idx;
	spi_master_pkg::word_t last_rx;

	// serial engine
	spi_master_pkg::ser_state_e sstate;
	logic        is_send;
	logic        cmd_run;
	logic        dma_run;
	logic [3:0]  nbytes;
	logic [3:0]  bidx;
	logic [2:0]  bitcnt;
	logic        pend;
	logic        all_done;
	logic        rx_half;
	spi_master_pkg::byte_t txs;
	spi_master_pkg::byte_t rxs;
	spi_master_pkg::byte_t rx_hi;

	logic [3:0]  sin;
	logic        rise;
	logic        fall;
	logic        run;

	logic        wr_ctrl;
	logic        wr_data;
	logic        wr_bctl;
	logic        wr_start;
	logic        wr_len;
	logic        improved;
	logic        data_ok;
	logic        ser_busy;
	logic        dma_idle;
	logic        clr_req;
	logic        sw_send;
	logic        sw_recv;
	logic        dma_kick;
	logic        start;
	logic        launch;
	logic        advance;
	logic [3:0]  step;
	logic        smp;
	logic        shf;
	logic [3:0]  bit_sum;
	logic        byte_end;
	logic        cur_tx;
	logic        last_byte;
	logic        rx_store;
	logic        finish;
	spi_master_pkg::byte_t rx_next;
	spi_master_pkg::word_t rx_word;
	spi_master_pkg::word_t tx_src;
	spi_master_pkg::byte_t tx_byte;
	spi_master_pkg::byte_t first_byte;
	spi_master_pkg::word_t rmux;
	logic [3:0]  next_out;
	logic [3:0]  next_oe;
	logic [4:0]  sent_words;

	// shifts a byte left by one lane group, filling from the data lines
	function automatic spi_master_pkg::byte_t lane_shift(
		input spi_master_pkg::byte_t v,
		input logic [3:0] ins,
		input logic [3:0] st);
		case (st)
			4'h1: lane_shift = {v[6:0], ins[0]};
			4'h2: lane_shift = {v[5:0], ins[1:0]};
			default: lane_shift = {v[3:0], ins};
		endcase
	endfunction

	spi_line_sync u_sync
	(
		.clk  (clk),
		.rstn (rstn),
		.ce   (ce),
		.din  (sio_in),
		.dout (sin)
	);

	spi_rate_gen u_rate
	(
		.clk         (clk),
		.rstn        (rstn),
		.ce          (ce),
		.run         (run),
		.rate_select (rate_select), // RQ2
		.sck         (sck),
		.rise        (rise),
		.fall        (fall)
	);

	// register decode
	assign wr_ctrl  = wr && (addr == `ADR_XFER_CTRL);
	assign wr_data  = wr && (addr == `ADR_SER_WORD);
	assign wr_bctl  = wr && (addr == `ADR_BLK_CTRL);
	assign wr_start = wr && (addr == `ADR_BLK_START);
	assign wr_len   = wr && (addr == `ADR_BLK_LEN);

	assign improved = set_mode && mode_sel; // RQ19
	assign ser_busy = sstate == spi_master_pkg::SER_RUN;
	assign dma_idle = dstate == spi_master_pkg::DMA_IDLE;
	// legacy mode refuses data writes while a transfer is running; reads are not gated
	assign data_ok  = improved || !ser_busy; // RQ20
	assign clr_req  = wr_ctrl && wdata[`F_CLR]; // RQ10
	assign sw_send  = wr_ctrl && wdata[`F_SEND] && !wdata[`F_CLR]
		&& master_enable && !ser_busy && dma_idle
		&& (wdata[`F_CNT_HI:0] != 4'h0); // RQ8 RQ1
	assign sw_recv  = wr_ctrl && wdata[`F_RCV] && !wdata[`F_SEND]
		&& !wdata[`F_CLR] && master_enable && !ser_busy && dma_idle
		&& (wdata[`F_CNT_HI:0] != 4'h0); // RQ9 RQ1
	assign dma_kick = (dstate == spi_master_pkg::DMA_KICK) && !ser_busy;
	assign start    = sw_send || sw_recv || dma_kick;
	assign launch   = wr_len && dma_en && master_enable && dma_idle
		&& (wdata[`LEN_HI:0] != 12'h000); // RQ17 RQ14

	// lane width and edge roles
	assign step = !multi_en ? 4'h1 : (quad_sel ? 4'h4 : 4'h2); // RQ5
	assign smp  = mode_sel ? fall : rise; // RQ6
	assign shf  = mode_sel ? rise : fall;

	assign bit_sum   = {1'b0, bitcnt} + step;
	assign byte_end  = bit_sum[3];
	assign cur_tx    = is_send || (cmd_run && (bidx == 4'h0)); // RQ12
	assign last_byte = bidx == nbytes - 4'h1;
	assign rx_next   = lane_shift(rxs, sin, step);
	assign rx_word   = rx_half ? {rx_hi, rx_next} : {rx_next, 8'h00};
	assign rx_store  = ser_busy && smp && !all_done && byte_end && !cur_tx
		&& (rx_half || last_byte);
	// the clock is let back to rest before the transfer is closed
	assign finish    = ser_busy && all_done && !sck; // RQ23
	assign run       = ser_busy && !finish; // RQ23

	assign tx_idx     = rptr + bidx[2:1];
	assign tx_src     = dma_run ? dma_word : buf_mem[tx_idx];
	assign tx_byte    = bidx[0] ? tx_src[7:0] : tx_src[15:8];
	// the trigger write's own command bit counts, not the stored one
	assign first_byte = (sw_recv && wdata[`F_ICS]) ? `INT_CMD
		: dma_kick ? dma_word[15:8] : buf_mem[rptr][15:8];
	assign sent_words = 5'({1'b0, nbytes} + 5'h01) >> 1;

	// pin drive
	assign next_out = (step == 4'h1) ? {2'b00, txs[7], 1'b0}
		: (step == 4'h2) ? {2'b00, txs[7:6]} : txs[7:4];
	assign next_oe  = !run ? 4'h0
		: (step == 4'h1) ? 4'h2
		: !cur_tx ? 4'h0
		: (step == 4'h2) ? 4'h3 : 4'hF; // RQ4

	// register read selection
	assign rmux = (addr == `ADR_XFER_CTRL) ? {mode_sel, rate_select,
			internal_command_select, 1'b0, quad_sel, multi_en,
			transfer_done_flag, 1'b0, ser_busy && !is_send,
			ser_busy && is_send, byte_total}
		: (addr == `ADR_SER_WORD) ? last_rx // RQ13
		: (addr == `ADR_BLK_CTRL) ? {10'h000, new_event_mode, set_mode,
			index_auto_rewind, dma_dir, dma_en, !dma_idle} // RQ14
		: (addr == `ADR_BLK_LEN) ? {4'h0, word_count}
		: 16'h0000;

	// block engine sequencing
	assign advance = (dstate == spi_master_pkg::DMA_STORE)
		|| ((dstate == spi_master_pkg::DMA_WAIT) && finish && !dma_dir);
	assign sram_re   = dstate == spi_master_pkg::DMA_READ;
	assign sram_we   = dstate == spi_master_pkg::DMA_STORE;
	assign sram_addr = idx;
	assign sram_wdata = last_rx;

	always_comb
	begin
		next_dstate = dstate;
		unique case (dstate)
			spi_master_pkg::DMA_IDLE:
				if (launch)
					next_dstate = wdata[`LEN_HI:0] == 12'h000 ? dstate
						: dma_dir ? spi_master_pkg::DMA_KICK
						: spi_master_pkg::DMA_READ; // RQ15
			spi_master_pkg::DMA_READ:
				next_dstate = spi_master_pkg::DMA_LOAD;
			spi_master_pkg::DMA_LOAD:
				next_dstate = spi_master_pkg::DMA_KICK;
			spi_master_pkg::DMA_KICK:
				if (!ser_busy)
					next_dstate = spi_master_pkg::DMA_WAIT;
			spi_master_pkg::DMA_WAIT:
				if (finish && dma_dir)
					next_dstate = spi_master_pkg::DMA_STORE;
			spi_master_pkg::DMA_STORE:
				next_dstate = dstate;
		endcase
		if (advance)
			next_dstate = (left == 12'h001) ? spi_master_pkg::DMA_IDLE
				: dma_dir ? spi_master_pkg::DMA_KICK
				: spi_master_pkg::DMA_READ;
		if (clr_req || !dma_en)
			next_dstate = spi_master_pkg::DMA_IDLE; // RQ14
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			mode_sel                <= 1'b0;
			rate_select             <= 3'h0;
			internal_command_select <= 1'b0;
			quad_sel                <= 1'b0;
			multi_en                <= 1'b0;
			byte_total              <= `CNT_RST;
		end
		else if (ce && wr_ctrl)
		begin
			mode_sel                <= wdata[`F_MODE];
			rate_select             <= wdata[`F_RATE_HI:`F_RATE_LO];
			internal_command_select <= wdata[`F_ICS];
			quad_sel                <= wdata[`F_QSEL];
			multi_en                <= wdata[`F_MULTI];
			byte_total              <= wdata[`F_CNT_HI:0];
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			new_event_mode     <= 1'b0;
			set_mode           <= 1'b0;
			index_auto_rewind  <= 1'b0;
			dma_dir            <= 1'b0;
			dma_en             <= 1'b0;
			sram_start_pointer <= 14'h0000;
			word_count         <= 12'h000;
		end
		else if (ce)
		begin
			if (wr_bctl)
			begin
				new_event_mode    <= wdata[`F_NEWINT];
				set_mode          <= wdata[`F_SETMODE];
				index_auto_rewind <= wdata[`F_REWIND];
				dma_dir           <= wdata[`F_DIR];
				dma_en            <= wdata[`F_BEN];
			end
			if (wr_start)
				sram_start_pointer <= wdata[`START_HI:0]; // RQ17
			if (wr_len)
				word_count <= wdata[`LEN_HI:0];
		end
	end

	// set wins over clear
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			transfer_done_flag <= 1'b0;
		else if (ce)
		begin
			if (finish)
				transfer_done_flag <= 1'b1; // RQ11
			else if (clr_req)
				transfer_done_flag <= 1'b0; // RQ10
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			dstate    <= spi_master_pkg::DMA_IDLE;
			idx       <= 14'h0000;
			left      <= 12'h000;
			dma_word  <= 16'h0000;
			dma_event <= 1'b0;
		end
		else if (ce)
		begin
			dstate    <= next_dstate;
			dma_event <= 1'b0;
			if (launch)
			begin
				idx  <= sram_start_pointer;
				left <= wdata[`LEN_HI:0];
			end
			if (dstate == spi_master_pkg::DMA_LOAD)
				dma_word <= sram_rdata;
			// legacy mode signals when the last word is handed over
			if (dma_kick && left == 12'h001 && !new_event_mode)
				dma_event <= 1'b1; // RQ21
			if (advance)
			begin
				idx  <= idx + 14'h0001;
				left <= left - 12'h001;
				if (left == 12'h001)
				begin
					dma_event <= new_event_mode; // RQ21
					if (index_auto_rewind)
						idx <= sram_start_pointer; // RQ16
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sstate   <= spi_master_pkg::SER_IDLE;
			is_send  <= 1'b0;
			cmd_run  <= 1'b0;
			dma_run  <= 1'b0;
			nbytes   <= 4'h0;
			bidx     <= 4'h0;
			bitcnt   <= 3'h0;
			pend     <= 1'b0;
			all_done <= 1'b0;
			rx_half  <= 1'b0;
			txs      <= 8'h00;
			rxs      <= 8'h00;
			rx_hi    <= 8'h00;
		end
		else if (ce)
		begin
			if (clr_req || finish)
				sstate <= spi_master_pkg::SER_IDLE;
			else if (start)
			begin
				sstate   <= spi_master_pkg::SER_RUN;
				is_send  <= dma_kick ? !dma_dir : sw_send; // RQ15
				cmd_run  <= sw_recv && wdata[`F_ICS]; // RQ12
				dma_run  <= dma_kick;
				nbytes   <= dma_kick ? `DMA_WORD_BYTES
					: wdata[`F_CNT_HI:0]; // RQ7
				bidx     <= 4'h0;
				bitcnt   <= 3'h0;
				pend     <= 1'b0;
				all_done <= 1'b0;
				rx_half  <= 1'b0;
				txs      <= first_byte;
			end
			else if (ser_busy && smp && !all_done)
			begin
				rxs    <= rx_next;
				bitcnt <= bit_sum[2:0];
				pend   <= 1'b1;
				if (byte_end)
				begin
					bidx     <= bidx + 4'h1;
					all_done <= last_byte; // RQ7
					if (!cur_tx)
					begin
						rx_half <= !rx_half;
						rx_hi   <= rx_next;
					end
				end
			end
			else if (ser_busy && shf && pend)
			begin
				pend <= 1'b0;
				txs  <= (bitcnt == 3'h0) ? tx_byte
					: lane_shift(txs, 4'h0, step);
			end
		end
	end

	// buffer: software writes and received words share one ring
	always_ff @(posedge clk)
	begin
		if (ce)
		begin
			if (rx_store && !dma_run)
				buf_mem[wptr] <= rx_word; // RQ3 RQ9
			else if (wr_data && data_ok)
				buf_mem[wptr] <= wdata; // RQ13
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wptr    <= 2'h0;
			rptr    <= 2'h0;
			last_rx <= 16'h0000;
		end
		else if (ce)
		begin
			if (rx_store)
				last_rx <= rx_word; // RQ13
			if ((rx_store && !dma_run) || (wr_data && data_ok))
				wptr <= wptr + 2'h1;
			if (rx_store && !dma_run)
				rptr <= rptr + 2'h1;
			else if (finish && is_send && !dma_run)
				rptr <= rptr + sent_words[1:0];
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sio_out <= 4'h0;
			sio_oe  <= 4'h0;
			rdata   <= 16'h0000;
		end
		else if (ce)
		begin
			sio_out <= next_out;
			sio_oe  <= next_oe; // RQ4
			rdata   <= rd ? rmux : 16'h0000;
		end
	end
endmodule

/* sim/spi_master_with_dma_checker.sv */
// port assertions for the spi master with block-move engine
// bound into spi_master_with_dma; one clock domain, ce held high
`timescale 1ns/1ps
module spi_master_with_dma_checker
(
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic [7:0]  addr,
	input wire logic        rd,
	input wire logic [15:0] rdata,
	input wire logic        sck,
	input wire logic [3:0]  sio_oe,
	input wire logic        sram_we,
	input wire logic        sram_re,
	input wire logic        dma_event
);
	logic [7:0] hi_cnt;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// slowest rate keeps sck high 25 cycles; more means a stuck clock
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			hi_cnt <= 8'h00;
		else
			hi_cnt <= sck ? hi_cnt + 8'h01 : 8'h00;
	property p_rdata_idle; !$past(rd) |-> rdata == 16'h0000; endproperty
	property p_wo_read; rd && addr == 8'h54 |=> rdata == 16'h0000; endproperty
	property p_hi_min; $rose(sck) |-> sck [*4]; endproperty
	property p_lo_min; $fell(sck) |-> !sck [*4]; endproperty
	property p_hi_max; sck |-> hi_cnt <= 8'h18; endproperty
	property p_lanes; sio_oe inside {4'h0, 4'h2, 4'h3, 4'hF}; endproperty
	property p_excl; !(sram_we && sram_re); endproperty
	property p_re_pulse; sram_re |=> !sram_re; endproperty
	property p_ev_pulse; dma_event |=> !dma_event; endproperty
	property p_mem_idle; sram_we || sram_re |-> !sck; endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data not idle");
	a_wo_read: assert property (p_wo_read)
		else $error("start pointer readable");
	a_hi_min: assert property (p_hi_min)
		else $error("sck high phase too short");
	a_lo_min: assert property (p_lo_min)
		else $error("sck low phase too short");
	a_hi_max: assert property (p_hi_max)
		else $error("sck stuck high");
	a_lanes: assert property (p_lanes)
		else $error("illegal lane enables");
	a_excl: assert property (p_excl)
		else $error("sram read and write together");
	a_re_pulse: assert property (p_re_pulse)
		else $error("sram read longer than one cycle");
	a_ev_pulse: assert property (p_ev_pulse)
		else $error("block event longer than one cycle");
	a_mem_idle: assert property (p_mem_idle)
		else $error("sck running during sram access");
	c_event: cover property (dma_event);
	c_store: cover property (sram_we);
	c_quad: cover property (sio_oe == 4'hF);
endmodule

bind spi_master_with_dma spi_master_with_dma_checker chk
(
	.clk, .rstn, .addr, .rd, .rdata, .sck, .sio_oe, .sram_we, .sram_re,
	.dma_event
);

/* sim/spi_flash_model.sv */
// behavioural serial slave on the master's data lines, single-line data
// chip select, sample edge and reply pattern come from the bench
`timescale 1ns/1ps
module spi_flash_model
(
	input  wire logic        clk,
	input  wire logic        sck,
	input  wire logic        cs_n,
	input  wire logic        late,
	input  wire logic [3:0]  sio_out,
	input  wire logic [3:0]  sio_oe,
	input  wire logic [15:0] tx_pat,
	output logic      [3:0]  sio_in,
	output logic      [31:0] rx_bits,
	output logic      [7:0]  rises
);
	logic [3:0]  idx_r;
	logic [3:0]  idx_f;
	logic [31:0] rx_r;
	logic [31:0] rx_f;
	logic [3:0]  idx;
	logic        drive;
	logic        junk = 1'b0;
	// undriven lines wander so a stale level never passes as data
	always @(posedge clk)
		junk <= ~junk;
	always @(posedge sck or posedge cs_n)
		if (cs_n)
		begin
			idx_r <= 4'h0;
			rises <= 8'h00;
		end
		else
		begin
			idx_r <= idx_r + 4'h1;
			rises <= rises + 8'h01;
			rx_r  <= {rx_r[30:0], sio_out[1]};
		end
	always @(negedge sck or posedge cs_n)
		if (cs_n)
			idx_f <= 4'h0;
		else
		begin
			idx_f <= idx_f + 4'h1;
			rx_f  <= {rx_f[30:0], sio_out[1]};
		end
	assign idx     = late ? idx_r - 4'h1 : idx_f;
	assign rx_bits = late ? rx_f : rx_r;
	assign drive   = !cs_n && !sio_oe[0];
	assign sio_in  = (sio_oe & sio_out) |
		(~sio_oe & {{3{junk}}, drive ? tx_pat[4'hF - idx] : junk});
endmodule

/* sim/tb.sv */
// self-checking bench: register port, serial link and block moves
// flash model on the link; working sram modelled inline
`timescale 1ns/1ps
module tb;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        ce = 1'b1;
	logic        master_enable = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [15:0] sram_rdata = 16'h0000;
	logic        cs_n = 1'b0;
	logic        late = 1'b0;
	logic [15:0] tx_pat = 16'h0000;
	logic [15:0] rdata, sram_wdata, we_data;
	logic [13:0] sram_addr, we_addr;
	logic [3:0]  sio_in, sio_out, sio_oe;
	logic        sck, sram_we, sram_re, dma_event;
	logic [31:0] rx_bits;
	logic [7:0]  rises;
	int          mismatches = 0;
	int          checks_done = 0;
	int          cycles = 0;
	int          we_cnt = 0;
	int          half[6] = '{4, 7, 8, 10, 13, 25};
	logic [7:0]  ra[5] = '{8'h0D, 8'h53, 8'h55, 8'h54, 8'h20};
	logic [15:0] rv[5] = '{16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
	spi_master_with_dma dut
	(
		.clk, .rstn, .ce, .master_enable, .addr, .wdata, .wr, .rd, .rdata,
		.sck, .sio_in, .sio_out, .sio_oe, .sram_addr, .sram_wdata,
		.sram_we, .sram_re, .sram_rdata, .dma_event
	);
	spi_flash_model flash
	(
		.clk, .sck, .cs_n, .late, .sio_out, .sio_oe, .tx_pat, .sio_in,
		.rx_bits, .rises
	);
	initial
		forever #2.5 clk = ~clk;
	function automatic logic [15:0] sram_word(input logic [13:0] a);
		return 16'h5A00 ^ {2'h0, a};
	endfunction
	// working sram answers one cycle after the read strobe
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (sram_re)
			sram_rdata <= sram_word(sram_addr);
		if (sram_we)
		begin
			we_cnt  <= we_cnt + 1;
			we_data <= sram_wdata;
			we_addr <= sram_addr;
		end
		if (cycles == 40000)
		begin
			mismatches = mismatches + 1;
			test_done();
		end
	end
	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checks_done++;
		if (exp !== got)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic wait_done();
		logic [15:0] s;
		s = 16'h0000;
		for (int i = 0; i < 600 && s[7] !== 1'b1; i++)
			rreg(8'h0D, s);
		check("done flag", 1'b1, s[7]);
	endtask
	task automatic clear_flags();
		logic [15:0] s;
		cs_n <= 1'b1;
		late <= 1'b0;
		wreg(8'h0D, 16'h0040);
		rreg(8'h0D, s);
		check("done after clear", 1'b0, s[7]);
	endtask
	task automatic wait_event();
		for (int i = 0; i < 3000 && dma_event !== 1'b1; i++)
			@(posedge clk) #1;
		check("block event", 1'b1, dma_event);
	endtask
	task automatic t_reset();
		logic [15:0] s;
		foreach (ra[i])
		begin
			rreg(ra[i], s);
			check("reset value", rv[i], s);
		end
		$display("test reset done");
	endtask
	task automatic t_gate();
		logic [15:0] s;
		cs_n <= 1'b0;
		wreg(8'h0D, 16'h0022);
		repeat (40) @(posedge clk);
		rreg(8'h0D, s);
		check("no clock while disabled", 0, rises);
		check("idle while disabled", 2'h0, {s[7], s[5]});
		master_enable <= 1'b1;
		clear_flags();
		$display("test gate done");
	endtask
	task automatic t_send(input logic [2:0] rate, input logic [1:0] lanes,
		input logic [3:0] oe);
		int n;
		int nr;
		n = 0;
		nr = lanes == 2'h3 ? 4 : lanes == 2'h1 ? 8 : 16;
		cs_n <= 1'b0;
		wreg(8'h0E, 16'hA55A);
		wreg(8'h0D, {1'b0, rate, 2'h0, lanes, 8'h12});
		for (int i = 0; i < 200 && sck !== 1'b1; i++)
			@(posedge clk) #1;
		while (sck === 1'b1 && n < 40)
		begin
			n++;
			@(posedge clk) #1;
		end
		check("high phase", half[rate], n);
		check("lanes driven", oe, sio_oe);
		wait_done();
		check("sck rises", nr, rises);
		if (lanes == 2'h0)
			check("word sent", 16'hA55A, rx_bits[15:0]);
		clear_flags();
		$display("test send done");
	endtask
	task automatic t_recv(input logic mode);
		logic [15:0] s;
		logic [15:0] pat;
		pat = mode ? 16'h3C96 : 16'hC369;
		late   <= mode;
		tx_pat <= pat;
		cs_n   <= 1'b0;
		wreg(8'h0D, {mode, 7'h00, 8'h22});
		wait_done();
		rreg(8'h0E, s);
		check("word received", pat, s);
		check("sck rises", 16, rises);
		clear_flags();
		$display("test receive done");
	endtask
	task automatic t_cmd();
		logic [15:0] s;
		tx_pat <= 16'hB4D2;
		cs_n   <= 1'b0;
		wreg(8'h0D, 16'h0823);
		wait_done();
		rreg(8'h0E, s);
		check("command byte", 8'h03, rx_bits[23:16]);
		check("word after command", 16'hD2B4, s);
		check("sck rises", 24, rises);
		clear_flags();
		$display("test command done");
	endtask
	task automatic t_dma_tx();
		logic [15:0] s;
		logic [31:0] w;
		w = {sram_word(14'h0010), sram_word(14'h0011)};
		cs_n <= 1'b0;
		wreg(8'h53, 16'h002A);
		wreg(8'h54, 16'h0010);
		wreg(8'h55, 16'h0002);
		rreg(8'h53, s);
		check("engine busy", 1'b1, s[0]);
		wait_event();
		check("bits out at event", 32, rises);
		check("words sent", w, rx_bits);
		rreg(8'h53, s);
		check("engine idle", 16'h002A, s);
		check("index rewound", 14'h0010, sram_addr);
		cs_n <= 1'b1;
		$display("test block send done");
	endtask
	task automatic t_dma_rx();
		logic [15:0] s;
		int          n0;
		n0 = we_cnt;
		tx_pat <= 16'hE71B;
		// deselect across one edge so the flash model restarts its counts
		@(posedge clk);
		cs_n   <= 1'b0;
		wreg(8'h53, 16'h0026);
		wreg(8'h54, 16'h3FF0);
		wreg(8'h55, 16'h0002);
		wait_event();
		check("stores", 2, we_cnt - n0);
		check("stored word", 16'hE71B, we_data);
		check("store index", 14'h3FF1, we_addr);
		check("index kept", 14'h3FF2, sram_addr);
		rreg(8'h55, s);
		check("length readback", 16'h0002, s);
		wreg(8'h53, 16'h0000);
		cs_n <= 1'b1;
		$display("test block receive done");
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		// rising select clears the flash model's counters before use
		cs_n <= 1'b1;
		t_reset();
		t_gate();
		for (int r = 0; r < 6; r++)
			t_send(r[2:0], 2'h0, 4'h2);
		t_send(3'h0, 2'h1, 4'h3);
		t_send(3'h0, 2'h3, 4'hF);
		t_recv(1'b0);
		t_recv(1'b1);
		t_cmd();
		t_dma_tx();
		t_dma_rx();
		test_done();
	end
endmodule
